// >>> src/divp_map.svh
`ifndef DIVP_MAP_SVH
`define DIVP_MAP_SVH
// register byte offsets
`define DIVP_OFS_FLAGS 4'h0
`define DIVP_OFS_MASK 4'h4
`define DIVP_OFS_SEL 4'h8
`define DIVP_OFS_VEC 4'hC
// reset values
`define DIVP_RST_FLAGS 16'h0000
`define DIVP_RST_MASK 16'h0000
`define DIVP_RST_SEL 4'h0
// bits that carry a source; 15 and 14 are reserved
`define DIVP_USED_BITS 16'h3FFF
// flag and mask bit positions
`define DIVP_BIT_EXT0 0
`define DIVP_BIT_EXT1 1
`define DIVP_BIT_EXT2 2
`define DIVP_BIT_TMR0 3
`define DIVP_BIT_SP0_RX 4
`define DIVP_BIT_SP0_TX 5
`define DIVP_BIT_DMA0 6
`define DIVP_BIT_TMR1 7
`define DIVP_BIT_EXT3 8
`define DIVP_BIT_HOST 9
`define DIVP_BIT_SP1_RX 10
`define DIVP_BIT_SP1_TX 11
`define DIVP_BIT_DMA4 12
`define DIVP_BIT_DMA5 13
// select bits steering the shared slots
`define DIVP_SEL_SLOT6 0
`define DIVP_SEL_SLOT7 1
`define DIVP_SEL_SLOT10 2
`define DIVP_SEL_SLOT11 3
// trap numbers, vector spacing, priorities
`define DIVP_TRAP_RESET 5'h00
`define DIVP_TRAP_NMI 5'h01
`define DIVP_TRAP_SOFT 5'h0F
`define DIVP_TRAP_FIRST 5'h10
`define DIVP_TRAP_LAST 5'h1D
`define DIVP_VEC_SHIFT 2
`define DIVP_PRIO_RESET 5'h01
`define DIVP_PRIO_NMI 5'h02
`define DIVP_PRIO_NONE 5'h00
`define DIVP_PRIO_BIAS 5'h0D
// bus answers
`define DIVP_RESP_OKAY 2'h0
`define DIVP_RESP_SLVERR 2'h2
`endif

// >>> src/divp_pkg.sv
package divp_pkg;
   // whole state of the controller
   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] mask;
      logic [3:0] sel;
      logic rst_pend;
      logic nmi_pend;
      logic soft_pend;
      logic req;
      logic [4:0] trap;
      logic [6:0] vec;
      logic [4:0] prio;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } divp_state_t;
   typedef logic [31:0] divp_word_t;
endpackage

// >>> src/divp_top.sv
// Operation
// - reset is trap 0 offset 00h priority 1; nmi trap 1 offset 04h priority 2
// - software trap 15 at offset 3Ch, no hardware priority, software only
// - external 0,1,2 at 40h,44h,48h prio 3-5; timer 0 at 4Ch prio 6
// - serial 0 receive at 50h prio 7, transmit at 54h prio 8
// - slot 58h prio 9 reserved, or dma channel 0 when selected
// - slot 5Ch prio 10 timer 1, or dma channel 1 when selected
// - external 3 at 60h prio 11; host port at 64h prio 12
// - 68h and 6Ch serial 1 receive/transmit, or dma 2 and 3
// - dma 4 at 70h prio 15, dma 5 at 74h prio 16; traps 30-31 reserved
// - bits 15 and 14 of flags and mask carry no source
// - bits 0-2 external interrupts 0-2, bit 3 timer 0
// - bit 4 serial 0 receive, bit 5 serial 0 transmit
// - bit 6 reserved, or dma channel 0 when selected
// - bit 7 timer 1 or dma channel 1 by selection
// - bit 8 external 3, bit 9 host port
// - bits 10 and 11 serial 1 receive/transmit, or dma 2 and 3
// - bit 12 dma channel 4, bit 13 dma channel 5
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "divp_map.svh"
module divp_top
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   // peripheral interrupt sources, one-cycle pulses
   input wire logic EXT_IRQ_ZERO,
   input wire logic EXT_IRQ_ONE,
   input wire logic EXT_IRQ_TWO,
   input wire logic EXT_IRQ_THREE,
   input wire logic TIMER_ZERO_IRQ,
   input wire logic TIMER_ONE_IRQ,
   input wire logic SERIAL0_RX_IRQ,
   input wire logic SERIAL0_TX_IRQ,
   input wire logic SERIAL1_RX_IRQ,
   input wire logic SERIAL1_TX_IRQ,
   input wire logic HOST_PORT_IRQ,
   input wire logic DMA_CH0_IRQ,
   input wire logic DMA_CH1_IRQ,
   input wire logic DMA_CH2_IRQ,
   input wire logic DMA_CH3_IRQ,
   input wire logic DMA_CH4_IRQ,
   input wire logic DMA_CH5_IRQ,
   input wire logic NMI_REQ,
   input wire logic SOFT_TRAP_THIRTY,
   // processor core side
   output logic CORE_REQ,
   output logic [4:0] CORE_TRAP,
   output logic [6:0] CORE_VEC,
   output logic [4:0] CORE_PRIO,
   input wire logic CORE_ACK,
   output logic IRQ,
   // axi4-lite write address
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // axi4-lite write data
   input wire divp_pkg::divp_word_t WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // axi4-lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read address
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   // axi4-lite read data
   output divp_pkg::divp_word_t RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   import divp_pkg::*;

   divp_state_t s_q;
   divp_state_t s_d;
   logic [15:0] set_w;
   logic [15:0] pend_w;
   logic [15:0] clr_w;
   logic [3:0] idx_w;
   logic wr_go;
   logic rd_go;
   logic wr_bad;
   logic [15:0] wr_val;
   logic [15:0] vec_word;

   // source routing into flag bits
   always_comb
   begin
      set_w = 16'h0000;
      set_w[`DIVP_BIT_EXT0] = EXT_IRQ_ZERO;
      set_w[`DIVP_BIT_EXT1] = EXT_IRQ_ONE;
      set_w[`DIVP_BIT_EXT2] = EXT_IRQ_TWO;
      set_w[`DIVP_BIT_TMR0] = TIMER_ZERO_IRQ;
      set_w[`DIVP_BIT_SP0_RX] = SERIAL0_RX_IRQ;
      set_w[`DIVP_BIT_SP0_TX] = SERIAL0_TX_IRQ;
      set_w[`DIVP_BIT_DMA0] = s_q.sel[`DIVP_SEL_SLOT6] & DMA_CH0_IRQ;
      set_w[`DIVP_BIT_TMR1] = s_q.sel[`DIVP_SEL_SLOT7] ? DMA_CH1_IRQ
                                                        : TIMER_ONE_IRQ;
      set_w[`DIVP_BIT_EXT3] = EXT_IRQ_THREE;
      set_w[`DIVP_BIT_HOST] = HOST_PORT_IRQ;
      // serial 1 or dma 2 and 3
      set_w[`DIVP_BIT_SP1_RX] = s_q.sel[`DIVP_SEL_SLOT10] ? DMA_CH2_IRQ
                                                           : SERIAL1_RX_IRQ;
      set_w[`DIVP_BIT_SP1_TX] = s_q.sel[`DIVP_SEL_SLOT11] ? DMA_CH3_IRQ
                                                           : SERIAL1_TX_IRQ;
      set_w[`DIVP_BIT_DMA4] = DMA_CH4_IRQ;
      set_w[`DIVP_BIT_DMA5] = DMA_CH5_IRQ;
      set_w = set_w & `DIVP_USED_BITS;
   end

   // pending and enabled maskable sources
   assign pend_w = s_q.flags & s_q.mask & `DIVP_USED_BITS;
   // level interrupt line
   assign IRQ = |pend_w;

   // lowest set bit wins, bit 0 is priority 3
   always_comb
   begin
      idx_w = 4'hF;
      for (int i = 13; i >= 0; i--)
      begin
         if (pend_w[i])
            idx_w = 4'(i);
      end
   end

   // bus handshake terms
   assign AWREADY = !s_q.aw_got && !s_q.bvalid;
   assign WREADY = !s_q.w_got && !s_q.bvalid;
   assign ARREADY = !s_q.rvalid;
   assign wr_go = (s_q.aw_got || (AWVALID && AWREADY)) &&
                  (s_q.w_got || (WVALID && WREADY)) && !s_q.bvalid;
   assign rd_go = ARVALID && ARREADY;

   // readable view of the presented vector
   assign vec_word = {s_q.req, s_q.prio[2:0], s_q.trap, s_q.vec};

   // next state
   always_comb
   begin
      logic [7:0] wa;
      logic [31:0] wd;
      logic [3:0] ws;
      logic [4:0] trap_n;
      wa = s_q.aw_got ? s_q.awaddr : AWADDR;
      wd = s_q.w_got ? s_q.wdata : WDATA;
      ws = s_q.w_got ? s_q.wstrb : WSTRB;
      s_d = s_q;
      clr_w = 16'h0000;
      wr_bad = 1'b0;
      wr_val = 16'h0000;
      trap_n = `DIVP_TRAP_RESET;
      // write channel capture
      if (AWVALID && AWREADY && !wr_go)
      begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = AWADDR;
      end
      if (WVALID && WREADY && !wr_go)
      begin
         s_d.w_got = 1'b1;
         s_d.wdata = WDATA;
         s_d.wstrb = WSTRB;
      end
      // register write with byte lanes
      if (wr_go)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `DIVP_RESP_OKAY;
         wr_bad = (wa[7:4] != 4'h0);
         if (wr_bad)
            s_d.bresp = `DIVP_RESP_SLVERR;
         else if (wa[3:0] == `DIVP_OFS_MASK)
         begin
            wr_val = s_q.mask;
            if (ws[0])
               wr_val[7:0] = wd[7:0];
            if (ws[1])
               wr_val[15:8] = wd[15:8];
            s_d.mask = wr_val & `DIVP_USED_BITS;
         end
         else if (wa[3:0] == `DIVP_OFS_SEL)
         begin
            if (ws[0])
               s_d.sel = wd[3:0];
         end
         else if (wa[3:0] != `DIVP_OFS_FLAGS)
         begin
            if (wa[3:0] != `DIVP_OFS_VEC)
               s_d.bresp = `DIVP_RESP_SLVERR;
         end
      end
      if (s_q.bvalid && BREADY)
         s_d.bvalid = 1'b0;
      // register read; flags clear on read
      if (rd_go)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = `DIVP_RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         if (ARADDR[7:4] != 4'h0)
            s_d.rresp = `DIVP_RESP_SLVERR;
         else
         begin
            unique case (ARADDR[3:0])
               `DIVP_OFS_FLAGS:
               begin
                  s_d.rdata[15:0] = s_q.flags;
                  clr_w = 16'hFFFF;
               end
               `DIVP_OFS_MASK: s_d.rdata[15:0] = s_q.mask;
               `DIVP_OFS_SEL: s_d.rdata[3:0] = s_q.sel;
               `DIVP_OFS_VEC: s_d.rdata[15:0] = vec_word;
               default: s_d.rresp = `DIVP_RESP_SLVERR;
            endcase
         end
      end
      if (s_q.rvalid && RREADY)
         s_d.rvalid = 1'b0;
      // core acknowledge clears the presented source
      if (CORE_ACK && s_q.req)
      begin
         if (s_q.trap == `DIVP_TRAP_RESET)
            s_d.rst_pend = 1'b0;
         else if (s_q.trap == `DIVP_TRAP_NMI)
            s_d.nmi_pend = 1'b0;
         else if (s_q.trap == `DIVP_TRAP_SOFT)
            s_d.soft_pend = 1'b0;
         else
            clr_w[4'(s_q.trap - `DIVP_TRAP_FIRST)] = 1'b1;
      end
      s_d.flags = ((s_q.flags & ~clr_w) | set_w) & `DIVP_USED_BITS;
      if (NMI_REQ)
         s_d.nmi_pend = 1'b1;
      // only a software trap raises this entry
      if (SOFT_TRAP_THIRTY)
         s_d.soft_pend = 1'b1;
      s_d.req = 1'b1;
      if (s_q.rst_pend)
      begin
         trap_n = `DIVP_TRAP_RESET;
         s_d.prio = `DIVP_PRIO_RESET;
      end
      else if (s_q.nmi_pend)
      begin
         trap_n = `DIVP_TRAP_NMI;
         s_d.prio = `DIVP_PRIO_NMI;
      end
      else if (|pend_w)
      begin
         trap_n = `DIVP_TRAP_FIRST + 5'(idx_w);
         s_d.prio = trap_n - `DIVP_PRIO_BIAS;
      end
      else if (s_q.soft_pend)
      begin
         trap_n = `DIVP_TRAP_SOFT;
         s_d.prio = `DIVP_PRIO_NONE;
      end
      else
      begin
         s_d.req = 1'b0;
         s_d.prio = `DIVP_PRIO_NONE;
      end
      // an acked source must not be shown again at once
      if (CORE_ACK && s_q.req && s_d.req && trap_n == s_q.trap)
         s_d.req = 1'b0;
      s_d.trap = trap_n;
      // offset is four times the trap, never 78h-7Fh
      s_d.vec = 7'(trap_n) << `DIVP_VEC_SHIFT;
   end

   // state register
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         s_q <= '0;
         s_q.flags <= `DIVP_RST_FLAGS;
         s_q.mask <= `DIVP_RST_MASK;
         s_q.sel <= `DIVP_RST_SEL;
         s_q.rst_pend <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // outputs from the state register
   assign CORE_REQ = s_q.req;
   assign CORE_TRAP = s_q.trap;
   assign CORE_VEC = s_q.vec;
   assign CORE_PRIO = s_q.prio;
   assign BVALID = s_q.bvalid;
   assign BRESP = s_q.bresp;
   assign RVALID = s_q.rvalid;
   assign RDATA = s_q.rdata;
   assign RRESP = s_q.rresp;

   // checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!ARST_N);

   sequence wr_taken;
      wr_go ##1 s_q.bvalid;
   endsequence

   sequence resp_held;
      (s_q.bvalid && !BREADY) ##1 s_q.bvalid;
   endsequence

   // the ack edge itself drops the request, so it is left out here
   a_reset_first: assert property (
      (s_q.rst_pend && !CORE_ACK) |=>
      s_q.req && s_q.trap == 5'h00 && s_q.vec == 7'h00)
      else $error("reset vector not presented first");
   a_nmi_next: assert property (
      (!s_q.rst_pend && s_q.nmi_pend) |=>
      s_q.trap == 5'h01 && s_q.vec == 7'h04 && s_q.prio == 5'h02)
      else $error("nmi not presented at 04h");
   a_soft_trap_vec: assert property (
      (!s_q.rst_pend && !s_q.nmi_pend && pend_w == 16'h0 && s_q.soft_pend)
      |=> s_q.trap == 5'h0F && s_q.vec == 7'h3C)
      else $error("software trap not at 3Ch");
   a_vec_offset: assert property (
      s_q.req |-> s_q.vec == {s_q.trap, 2'b00} && s_q.trap <= 5'h1D)
      else $error("vector offset does not match trap");
   a_flag_prio: assert property (
      (s_q.req && s_q.trap >= 5'h10) |->
      s_q.prio == s_q.trap - 5'h0D &&
      ($past(pend_w) & ((16'h0001 << (s_q.trap - 5'h10)) - 16'h0001))
      == 16'h0000)
      else $error("lower numbered source was passed over");
   a_flag_set: assert property (
      (|set_w) |=> (s_q.flags & $past(set_w)) == $past(set_w))
      else $error("request did not set its flag");
   a_reserved_bits: assert property (
      s_q.flags[15:14] == 2'b00 && s_q.mask[15:14] == 2'b00)
      else $error("reserved bit set");
   a_slot_reserved: assert property (
      (!s_q.sel[0] && !s_q.flags[6] && !rd_go) |=> !s_q.flags[6])
      else $error("reserved slot raised");
   a_slot_timer: assert property (
      (!s_q.sel[1] && TIMER_ONE_IRQ) |=> s_q.flags[7])
      else $error("timer 1 lost on shared bit");
   a_deselect_ignored: assert property (
      (s_q.sel[1] && !DMA_CH1_IRQ && !s_q.flags[7]) |=> !s_q.flags[7])
      else $error("deselected source reached shared bit");
   a_write_resp: assert property (
      wr_go |-> wr_taken)
      else $error("write response not raised");
   a_resp_held: assert property (
      (s_q.bvalid && !BREADY) |-> resp_held)
      else $error("write response not held");
   a_ack_once: assert property (
      (CORE_ACK && s_q.req) |=> !(s_q.req && s_q.trap == $past(s_q.trap)))
      else $error("acked source presented again at once");

endmodule // divp_top

// >>> testbench/divp_core_model.sv
`timescale 1ns/10ps
module divp_core_model
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // vector offered by the controller
   input wire logic req,
   input wire logic [4:0] trap,
   input wire logic [6:0] vec,
   input wire logic [4:0] prio,
   // bench control and record of taken vectors
   input wire logic ack_en,
   input wire logic [1:0] lat,
   output logic ack,
   output logic [16:0] taken,
   output int n_acks
);
   logic [1:0] cnt;
   // wait lat cycles on a request, then acknowledge for one cycle
   // core takes vector
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack <= 1'b0;
         cnt <= 2'h0;
         taken <= '0;
         n_acks <= 0;
      end
      else if (ack)
      begin
         ack <= 1'b0;
         cnt <= 2'h0;
         if (req)
         begin
            taken <= {trap, vec, prio};
            n_acks <= n_acks + 1;
         end
      end
      else if (req && ack_en)
      begin
         if (cnt == lat)
            ack <= 1'b1;
         else
            cnt <= cnt + 2'h1;
      end
      else
         cnt <= 2'h0;
   end
endmodule // divp_core_model

// >>> testbench/divp_top_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module divp_top_bench;
   import divp_pkg::*;
   logic SYS_CLK = 1'b0;
   logic ARST_N = 1'b0;
   logic [18:0] src = '0;
   logic CORE_REQ, CORE_ACK, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [4:0] CORE_TRAP, CORE_PRIO;
   logic [6:0] CORE_VEC;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0, ack_en = 1'b0;
   divp_word_t WDATA = 32'h0, RDATA, rd;
   logic [1:0] BRESP, RRESP, rsp, lat = 2'h0;
   logic [16:0] taken, ex;
   int n_acks, n_errors = 0, tests_run = 0, cycles = 0;
   // source index, select value, expected flag bit (15 means ignored)
   int tsrc[22] = '{0,1,2,3,4,5,6,7,8,9,10,11,12,13,14,15,16,6,14,7,10,11};
   int tsel[22] = '{0,0,0,0,0,0,1,0,0,0,0,0,0,0,2,4,8,0,0,15,15,15};
   int tbit[22] = '{0,1,2,3,4,5,6,7,8,9,10,11,12,13,7,10,11,15,15,15,15,15};

   always #4 SYS_CLK = ~SYS_CLK;

   divp_top dut
   (
      .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .EXT_IRQ_ZERO(src[0]),
      .EXT_IRQ_ONE(src[1]), .EXT_IRQ_TWO(src[2]), .TIMER_ZERO_IRQ(src[3]),
      .SERIAL0_RX_IRQ(src[4]), .SERIAL0_TX_IRQ(src[5]), .DMA_CH0_IRQ(src[6]),
      .TIMER_ONE_IRQ(src[7]), .EXT_IRQ_THREE(src[8]), .HOST_PORT_IRQ(src[9]),
      .SERIAL1_RX_IRQ(src[10]), .SERIAL1_TX_IRQ(src[11]),
      .DMA_CH4_IRQ(src[12]), .DMA_CH5_IRQ(src[13]), .DMA_CH1_IRQ(src[14]),
      .DMA_CH2_IRQ(src[15]), .DMA_CH3_IRQ(src[16]), .NMI_REQ(src[17]),
      .SOFT_TRAP_THIRTY(src[18]), .CORE_REQ(CORE_REQ),
      .CORE_TRAP(CORE_TRAP), .CORE_VEC(CORE_VEC), .CORE_PRIO(CORE_PRIO),
      .CORE_ACK(CORE_ACK), .IRQ(IRQ), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(1'b1),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
      .RRESP(RRESP), .RVALID(RVALID), .RREADY(1'b1)
   );

   divp_core_model core
   (
      .clk(SYS_CLK), .arst_n(ARST_N), .req(CORE_REQ), .trap(CORE_TRAP),
      .vec(CORE_VEC), .prio(CORE_PRIO), .ack_en(ack_en), .lat(lat),
      .ack(CORE_ACK), .taken(taken), .n_acks(n_acks)
   );

   // prints the counts and the verdict, then stops
   task automatic wrap_up();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // bus write: each channel released at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw = 1'b1, w = 1'b1, ta, tw, s = 1'b0;
      @(posedge SYS_CLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      while (aw || w)
      begin
         @(negedge SYS_CLK);
         ta = aw & AWREADY;
         tw = w & WREADY;
         @(posedge SYS_CLK);
         if (ta)
         begin
            aw = 1'b0;
            AWVALID <= 1'b0;
         end
         if (tw)
         begin
            w = 1'b0;
            WVALID <= 1'b0;
         end
      end
      while (!s)
      begin
         @(negedge SYS_CLK);
         s = BVALID;
         rsp = BRESP;
         @(posedge SYS_CLK);
      end
   endtask

   // bus read: result left in rd and rsp
   task automatic rdr(input logic [7:0] a);
      logic s = 1'b0;
      @(posedge SYS_CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      while (!s)
      begin
         @(negedge SYS_CLK);
         s = ARREADY;
         @(posedge SYS_CLK);
      end
      ARVALID <= 1'b0;
      s = 1'b0;
      while (!s)
      begin
         @(negedge SYS_CLK);
         s = RVALID;
         rd = RDATA;
         rsp = RRESP;
         @(posedge SYS_CLK);
      end
   endtask

   // one-cycle source pulse, then time for the vector to settle
   task automatic pulse(input logic [18:0] v);
      @(posedge SYS_CLK);
      src <= v;
      @(posedge SYS_CLK);
      src <= '0;
      repeat (2) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
   endtask

   task automatic wait_ack();
      int p = n_acks;
      while (n_acks == p) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
   endtask

   // cuts a hung run short
   always @(posedge SYS_CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (3) @(posedge SYS_CLK);
      ARST_N <= 1'b1;
      repeat (2) @(negedge SYS_CLK);
      `CHK({CORE_REQ, CORE_TRAP, CORE_VEC, CORE_PRIO}, 18'h20001)
      @(posedge SYS_CLK);
      ack_en <= 1'b1;
      wait_ack();
      rdr(8'h04);
      `CHK(rd, 32'h0)
      rdr(8'h10);
      `CHK({rsp, rd}, {2'h2, 32'h0})
      wr(8'h14, 32'h0);
      `CHK(rsp, 2'h2)
      wr(8'h04, 32'hFFFFFFFF);
      `CHK(rsp, 2'h0)
      rdr(8'h04);
      `CHK(rd, 32'h00003FFF)
      // every source through its slot; deselected sources ignored
      for (int k = 0; k < 22; k++)
      begin
         lat <= 2'(k % 3);
         wr(8'h08, tsel[k]);
         pulse(19'h1 << tsrc[k]);
         if (tbit[k] < 14)
         begin
            wait_ack();
            ex = {5'(16 + tbit[k]), 7'(64 + 4 * tbit[k]), 5'(3 + tbit[k])};
            `CHK(taken, ex)
         end
         else
            `CHK(CORE_REQ, 1'b0)
         rdr(8'h00);
         `CHK(rd, 32'h0)
      end
      // two pending: lower priority number shown first
      ack_en <= 1'b0;
      pulse(19'h02004);
      ex = {5'd18, 7'h48, 5'd5};
      `CHK({CORE_REQ, CORE_TRAP, CORE_VEC, CORE_PRIO}, {1'b1, ex})
      rdr(8'h0C);
      `CHK(rd, 32'h0000D948)
      ack_en <= 1'b1;
      wait_ack();
      wait_ack();
      `CHK(taken, {5'd29, 7'h74, 5'd16})
      // masked and deselected requests, then nmi before software trap
      ack_en <= 1'b0;
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h00000100);
      pulse(19'h04108);
      `CHK({IRQ, CORE_REQ, CORE_TRAP, CORE_PRIO}, 12'hF0B)
      rdr(8'h00);
      `CHK(rd, 32'h00000108)
      @(negedge SYS_CLK);
      `CHK({IRQ, CORE_REQ}, 2'b00)
      @(posedge SYS_CLK);
      ack_en <= 1'b1;
      pulse(19'h60000);
      wait_ack();
      `CHK(taken, {5'd1, 7'h04, 5'd2})
      wait_ack();
      `CHK(taken, {5'd15, 7'h3C, 5'd0})
      wrap_up();
   end
endmodule // divp_top_bench
